/* src/scior_pkg.sv */
// Package for the serial card I/O control register bank.
// Assumes a 32-bit host register port with word offsets as byte addresses.
package scior_pkg;
    localparam int NUM_CHAN = 20;
    localparam int NUM_LINES = 22;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_BASE_CONTROL = 8'h00;
    localparam logic [7:0] OFF_DESIGN_REVISION_ID = 8'h04;
    localparam logic [7:0] OFF_CHANNEL_START_SET = 8'h08;
    localparam logic [7:0] OFF_CHANNEL_START_CLEAR = 8'h0c;
    localparam logic [7:0] OFF_PARALLEL_OUT_DATA = 8'h10;
    localparam logic [7:0] OFF_PARALLEL_DIRECTION = 8'h14;
    localparam logic [7:0] OFF_RESISTIVE_TERMINATION = 8'h18;
    localparam logic [7:0] OFF_LINE_SOURCE_SELECT = 8'h1c;
    localparam logic [7:0] OFF_UPPER_LINES_CONTROL = 8'h20;
    localparam logic [7:0] OFF_SWITCH_STATUS = 8'h24;
    localparam logic [7:0] OFF_PIN_READBACK = 8'hc0;
    localparam logic [7:0] OFF_CAPACITIVE_TERMINATION = 8'hc8;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_MASTER_IRQ_EN = 0;
    localparam int BIT_SOFT_IRQ_SET = 1;
    localparam int BIT_MSG_IRQ_EN = 2;
    localparam int BIT_MSG_EVENT_CLEAR = 3;
    localparam int BIT_REF_CLK_SELECT = 4;
    localparam int BASE_CONTROL_WIDTH = 5;
    localparam int BIT_TEST_CLK_SELECT = 31;
    localparam int SWITCH_LSB = 16;
    localparam int ID_DESIGN_LSB = 16;
    // ------------------------------------------------------------
    // Reset values and ratios
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam int TX_HIGH_DIVIDE = 8;
    localparam int TX_LOW_DIVIDE = 100;
    localparam int START_CLEAR_SENSE_PERIODS = 12;
endpackage

/* src/scior_regs.sv */
// Control and status register bank of a multi-channel serial I/O card.
// Assumes a single-cycle host register port on sys_clk; pins come from outside.
`timescale 1ns/1ps
`default_nettype none
module scior_regs
#(
    // Arbitrary neutral values, not a real design code
    parameter logic [15:0] DESIGN_ID = 16'h00a5,
    parameter logic [15:0] CONFIG_REVISION = 16'h0001
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [scior_pkg::NUM_CHAN-1:0] chan_irq,
    input wire logic [scior_pkg::NUM_CHAN-1:0] chan_start_done,
    output logic carrier_irq,
    output logic message_interrupt_enable,
    output logic message_event_clear,
    output logic ref_clk_select,
    output logic [scior_pkg::NUM_CHAN-1:0] chan_start,
    input wire logic [scior_pkg::NUM_LINES-1:0] sm_line_out,
    input wire logic [scior_pkg::NUM_LINES-1:0] sm_line_oe,
    input wire logic test_clk,
    input wire logic [scior_pkg::NUM_LINES-1:0] line_in,
    output logic [scior_pkg::NUM_LINES-1:0] line_out,
    output logic [scior_pkg::NUM_LINES-1:0] line_oe,
    output logic [scior_pkg::NUM_LINES-1:0] resistive_term_on,
    output logic [scior_pkg::NUM_CHAN-1:0] capacitive_term_on,
    input wire logic [7:0] user_switch_bits
);
    import scior_pkg::*;

    // ------------------------------------------------------------
    // Operating notes
    // ------------------------------------------------------------
    // Host side
    // One word per access, byte offsets on reg_addr
    // Writes land on the taking edge
    // Reads return data one edge later
    // reg_rdata holds until the next read
    // Back to back accesses are allowed
    // No wait states are ever inserted
    // Unmapped offsets read zero
    // Writes to unmapped offsets vanish
    // Writes to read only ports vanish
    // Spare bits read zero everywhere
    //
    // Clock enable
    // clk_en low freezes every register
    // Strobes seen while frozen are lost
    // The host must hold clk_en high to access
    // Synchronisers freeze as well
    // A frozen bank still drives its outputs
    //
    // Reset
    // Synchronous, active high, one edge is enough
    // Every stored bit returns to zero
    // Outputs follow from the cleared state
    // All lines come up receiving
    // No termination switch closed after reset
    // Start bits all idle after reset
    //
    // Interrupt path
    // Channel requests arrive already enabled
    // Their sum is a plain OR, no latching here
    // Status latching lives in the channel logic
    // Master enable gates the carrier line
    // Soft set needs master enable as well
    // Soft set is meant for driver bring-up
    // The carrier line is combinational
    // A glitch on a channel request passes through
    // Message delivery is done outside this bank
    // Only its enable and clear leave here
    // Clear is a level while its bit stays high
    // Software must drop the clear bit itself
    // Pulse clear before enabling messages
    // That way stale events raise nothing
    //
    // Reference clock
    // Select bit only; dividers sit downstream
    // Rates stay in fixed ratio to the reference
    // Switching reference mid frame is unsafe
    // Stop channels before changing the select
    //
    // Start bits
    // Set port: ones set, zeros leave alone
    // Clear port: ones clear, zeros leave alone
    // Channels may drop their own start bit
    // Priority: set, then self clear, then clear
    // A set never loses to a same edge clear
    // Read back shows the active channels
    // Read back may change without a host write
    // Channels sample start on a slower clock
    // Allow a dozen channel periods for a clear
    // Poll the channel busy flag before restart
    //
    // Parallel lines
    // Data, direction, mux and terminations
    // Each line is chosen bit by bit
    // Mux one hands the line to its channel
    // Mux zero hands it to the host registers
    // Direction one drives, zero receives
    // Data reads return the stored word
    // The pin level may differ from the data
    // Pin levels are read from the read back port
    // Read back lags the pins by two edges
    // Read back is raw, with no filtering
    // Driven lines read back what is sent
    // Released lines read back what arrives
    // The two discretes are lines 21 and 20
    // Discretes carry levels, ports do not
    // Transformer lines block steady levels
    //
    // Terminations
    // Resistive switches cover all 22 lines
    // Capacitive switches cover the 20 ports
    // Both are independent of the mux
    // Both apply even while a line drives
    //
    // Test clock
    // Select bit sits atop the capacitor port
    // It forces all 20 ports to drive the clock
    // It overrides mux and data settings
    // Discretes keep their normal selection
    // The test clock is resynchronised here
    // Its rate is limited to below sys_clk / 2
    //
    // Upper lines port
    // Kept only for software compatibility
    // Reads zero and ignores every write
    //
    // Status port
    // User switch byte only, bits 23 to 16
    // Switches pass two flops before reading
    // Other status bits are reserved as zero
    //
    // Identifier
    // Upper half design, lower half revision
    // Both are parameters with neutral defaults

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [BASE_CONTROL_WIDTH-1:0] base_control_reg;
    logic [NUM_CHAN-1:0] start_reg;
    logic [NUM_CHAN-1:0] start_next;
    logic [NUM_LINES-1:0] out_data_reg;
    logic [NUM_LINES-1:0] direction_reg;
    logic [NUM_LINES-1:0] res_term_reg;
    logic [NUM_LINES-1:0] source_sel_reg;
    logic [NUM_CHAN-1:0] cap_term_reg;
    logic test_clk_sel_reg;
    logic [NUM_LINES-1:0] line_meta_reg;
    logic [NUM_LINES-1:0] line_sync_reg;
    logic [7:0] switch_meta_reg;
    logic [7:0] switch_sync_reg;
    logic test_clk_meta_reg;
    logic test_clk_sync_reg;
    logic [31:0] rdata_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    wire wr_base = reg_write && hit(reg_addr, OFF_BASE_CONTROL);
    wire wr_set = reg_write && hit(reg_addr, OFF_CHANNEL_START_SET);
    wire wr_clear = reg_write && hit(reg_addr, OFF_CHANNEL_START_CLEAR);
    wire wr_data = reg_write && hit(reg_addr, OFF_PARALLEL_OUT_DATA);
    wire wr_dir = reg_write && hit(reg_addr, OFF_PARALLEL_DIRECTION);
    wire wr_rterm = reg_write && hit(reg_addr, OFF_RESISTIVE_TERMINATION);
    wire wr_mux = reg_write && hit(reg_addr, OFF_LINE_SOURCE_SELECT);
    wire wr_cterm = reg_write && hit(reg_addr, OFF_CAPACITIVE_TERMINATION);

    // ------------------------------------------------------------
    // Base control register
    // ------------------------------------------------------------
    // cleared on reset
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            base_control_reg <= '0;
        else if (clk_en && wr_base)
            base_control_reg <= reg_wdata[BASE_CONTROL_WIDTH-1:0];
    end

    // soft set forces request
    // Channel events are summed here; per-channel enables live upstream
    wire irq_any = base_control_reg[BIT_SOFT_IRQ_SET] || (|chan_irq);
    assign carrier_irq = base_control_reg[BIT_MASTER_IRQ_EN] && irq_any;
    assign message_interrupt_enable = base_control_reg[BIT_MSG_IRQ_EN];
    assign message_event_clear = base_control_reg[BIT_MSG_EVENT_CLEAR];
    // reference source select; divide by 8 or 100 downstream
    assign ref_clk_select = base_control_reg[BIT_REF_CLK_SELECT];

    // ------------------------------------------------------------
    // Channel start bits
    // ------------------------------------------------------------
    // set writes ones only
    // clear port drops bit
    // A host set wins over a same-cycle clear so a start is never lost
    always_comb
    begin
        start_next = start_reg;
        if (wr_clear)
            start_next = start_next & ~reg_wdata[NUM_CHAN-1:0];
        start_next = start_next & ~chan_start_done;
        if (wr_set)
            start_next = start_next | reg_wdata[NUM_CHAN-1:0];
    end

    // channels sample start on their own slower clock
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            start_reg <= '0;
        else if (clk_en)
            start_reg <= start_next;
    end
    assign chan_start = start_reg;

    // ------------------------------------------------------------
    // Parallel port registers
    // ------------------------------------------------------------
    // only low 22 bits stored; capacitor port keeps bits 19:0 and bit 31
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            out_data_reg <= '0;
            direction_reg <= '0;
            res_term_reg <= '0;
            source_sel_reg <= '0;
            cap_term_reg <= '0;
            test_clk_sel_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_data)
                out_data_reg <= reg_wdata[NUM_LINES-1:0];
            if (wr_dir)
                direction_reg <= reg_wdata[NUM_LINES-1:0];
            if (wr_rterm)
                res_term_reg <= reg_wdata[NUM_LINES-1:0];
            if (wr_mux)
                source_sel_reg <= reg_wdata[NUM_LINES-1:0];
            if (wr_cterm)
            begin
                cap_term_reg <= reg_wdata[NUM_CHAN-1:0];
                test_clk_sel_reg <= reg_wdata[BIT_TEST_CLK_SELECT];
            end
        end
    end

    // Pins and switches cross in from outside: two flops each
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            line_meta_reg <= '0;
            line_sync_reg <= '0;
            switch_meta_reg <= '0;
            switch_sync_reg <= '0;
            test_clk_meta_reg <= 1'b0;
            test_clk_sync_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            line_meta_reg <= line_in;
            line_sync_reg <= line_meta_reg;
            switch_meta_reg <= user_switch_bits;
            switch_sync_reg <= switch_meta_reg;
            test_clk_meta_reg <= test_clk;
            test_clk_sync_reg <= test_clk_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Line drive selection, one slice per line
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++)
        begin : g_line
            wire to_sm = source_sel_reg[gi];
            // Test clock only exists on transformer lines
            wire test_on = test_clk_sel_reg && (gi < NUM_CHAN);
            assign line_out[gi] = test_on ? test_clk_sync_reg :
                                  (to_sm ? sm_line_out[gi] : out_data_reg[gi]);
            assign line_oe[gi] = test_on ? 1'b1 :
                                 (to_sm ? sm_line_oe[gi] : direction_reg[gi]);
        end
    endgenerate

    assign resistive_term_on = res_term_reg;
    assign capacitive_term_on = cap_term_reg;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // unmapped and reserved read zero
    always_comb
    begin
        rdata_next = RESET_ZERO;
        if (hit(reg_addr, OFF_BASE_CONTROL))
            rdata_next[BASE_CONTROL_WIDTH-1:0] = base_control_reg;
        else if (hit(reg_addr, OFF_DESIGN_REVISION_ID))
            rdata_next = {DESIGN_ID, CONFIG_REVISION};
        else if (hit(reg_addr, OFF_CHANNEL_START_SET))
            rdata_next[NUM_CHAN-1:0] = start_reg;
        else if (hit(reg_addr, OFF_PARALLEL_OUT_DATA))
            rdata_next[NUM_LINES-1:0] = out_data_reg;
        else if (hit(reg_addr, OFF_PARALLEL_DIRECTION))
            rdata_next[NUM_LINES-1:0] = direction_reg;
        else if (hit(reg_addr, OFF_RESISTIVE_TERMINATION))
            rdata_next[NUM_LINES-1:0] = res_term_reg;
        else if (hit(reg_addr, OFF_LINE_SOURCE_SELECT))
            rdata_next[NUM_LINES-1:0] = source_sel_reg;
        else if (hit(reg_addr, OFF_UPPER_LINES_CONTROL))
            rdata_next = RESET_ZERO;
        else if (hit(reg_addr, OFF_SWITCH_STATUS))
            rdata_next[SWITCH_LSB+7:SWITCH_LSB] = switch_sync_reg;
        else if (hit(reg_addr, OFF_PIN_READBACK))
            rdata_next[NUM_LINES-1:0] = line_sync_reg;
        else if (hit(reg_addr, OFF_CAPACITIVE_TERMINATION))
        begin
            rdata_next[NUM_CHAN-1:0] = cap_term_reg;
            rdata_next[BIT_TEST_CLK_SELECT] = test_clk_sel_reg;
        end
    end

    // Read data registered: valid the cycle after reg_read
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            reg_rdata <= RESET_ZERO;
        else if (clk_en && reg_read)
            reg_rdata <= rdata_next;
    end
endmodule
`default_nettype wire

/* tb/scior_regs_assertions.sv */
// Checker of the register bank port behaviour.
// Assumes one-cycle host strobes sampled on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module scior_chk
#(
    parameter logic [15:0] DESIGN_ID = 16'h00a5,
    parameter logic [15:0] CONFIG_REVISION = 16'h0001
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [scior_pkg::NUM_CHAN-1:0] chan_start_done,
    input wire logic carrier_irq,
    input wire logic message_interrupt_enable,
    input wire logic message_event_clear,
    input wire logic ref_clk_select,
    input wire logic [scior_pkg::NUM_CHAN-1:0] chan_start,
    input wire logic [scior_pkg::NUM_LINES-1:0] resistive_term_on
);
    import scior_pkg::*;
    // Host strobes taken at a rising edge
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_wr(logic [7:0] a);
        clk_en && reg_write && reg_addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        clk_en && reg_read && reg_addr == a;
    endsequence
    // Outputs tied to the strobe that caused them
    property p_rst;
        $fell(reset) |-> chan_start == '0 && !ref_clk_select && !carrier_irq && !message_interrupt_enable;
    endproperty
    property p_base;
        s_wr(8'h00) |=> ref_clk_select == $past(reg_wdata[4]) && message_interrupt_enable == $past(reg_wdata[2])
            && message_event_clear == $past(reg_wdata[3]);
    endproperty
    property p_soft;
        s_wr(8'h00) ##0 reg_wdata[1:0] == 2'h3 |=> carrier_irq;
    endproperty
    property p_mast;
        s_wr(8'h00) ##0 !reg_wdata[0] |=> !carrier_irq;
    endproperty
    property p_set;
        s_wr(8'h08) |=> (chan_start & $past(reg_wdata[NUM_CHAN-1:0])) == $past(reg_wdata[NUM_CHAN-1:0]);
    endproperty
    property p_clr;
        s_wr(8'h0c) |=> (chan_start & $past(reg_wdata[NUM_CHAN-1:0])) == '0;
    endproperty
    // A set write in the same cycle outranks the self-clear
    property p_done;
        clk_en && chan_start_done != '0 && !(reg_write && reg_addr == 8'h08) |=>
            (chan_start & $past(chan_start_done)) == '0;
    endproperty
    property p_id;
        s_rd(8'h04) |=> reg_rdata == {DESIGN_ID, CONFIG_REVISION};
    endproperty
    property p_unm;
        s_rd(8'h20) |=> reg_rdata == '0;
    endproperty
    property p_term;
        s_wr(8'h18) |=> resistive_term_on == $past(reg_wdata[NUM_LINES-1:0]);
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    a_base: assert property (p_base) else $error("base control fields wrong");
    a_soft: assert property (p_soft) else $error("forced interrupt missing");
    a_mast: assert property (p_mast) else $error("interrupt without master enable");
    a_set: assert property (p_set) else $error("start bits not set");
    a_clr: assert property (p_clr) else $error("start bits not cleared");
    a_done: assert property (p_done) else $error("self clear ignored");
    a_id: assert property (p_id) else $error("identifier read wrong");
    a_unm: assert property (p_unm) else $error("upper port not zero");
    a_term: assert property (p_term) else $error("termination not applied");
endmodule
bind scior_regs scior_chk #(.DESIGN_ID(DESIGN_ID), .CONFIG_REVISION(CONFIG_REVISION)) scior_chk_inst (.sys_clk,
    .reset, .clk_en, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .chan_start_done, .carrier_irq,
    .message_interrupt_enable, .message_event_clear, .ref_clk_select, .chan_start, .resistive_term_on);
`default_nettype wire

/* tb/scior_line_model.sv */
// Far end of the 22 I/O lines.
// Assumes line_oe high while the bank drives a line.
`timescale 1ns/1ps
`default_nettype none
module scior_line_model
(
    input wire logic sys_clk,
    input wire logic [21:0] line_out,
    input wire logic [21:0] line_oe,
    output logic [21:0] line_in
);
    logic [21:0] far_reg = 22'h15_5555;
    // Released lines toggle, so a stale level never looks right
    always @(posedge sys_clk)
        far_reg <= ~far_reg;
    assign line_in = (line_oe & line_out) | (~line_oe & far_reg);
endmodule
`default_nettype wire

/* tb/scior_regs_tb_top.sv */
// Self-checking bench of the register bank.
// Assumes the line model closes the pin loop.
`timescale 1ns/1ps
`default_nettype none
module scior_regs_tb_top;
    import scior_pkg::*;
    logic sys_clk = 0, reset = 1, clk_en = 1, reg_write = 0, reg_read = 0, test_clk = 0;
    logic [7:0] reg_addr = '0, user_switch_bits = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rnd = 32'h0000_c77a, d, m, r, v;
    logic [19:0] chan_irq = '0, chan_start_done = '0, chan_start, capacitive_term_on;
    logic [21:0] sm_line_out = '0, sm_line_oe = '0, line_in, line_out, line_oe, resistive_term_on, e;
    logic carrier_irq, message_interrupt_enable, message_event_clear, ref_clk_select;
    int fails = 0, comparisons = 0;
    localparam logic [7:0] OFFS [9] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'hc8};
    localparam logic [31:0] BASES [3] = '{32'h0000_0003, 32'h0000_0002, 32'hffff_fffe};
    // Clocks; the test clock toggles on every sys_clk rising edge
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) test_clk <= ~test_clk;
    scior_regs scior_regs_inst (.sys_clk, .reset, .clk_en, .reg_write, .reg_read, .reg_addr, .reg_wdata,
        .reg_rdata, .chan_irq, .chan_start_done, .carrier_irq, .message_interrupt_enable, .message_event_clear,
        .ref_clk_select, .chan_start, .sm_line_out, .sm_line_oe, .test_clk, .line_in, .line_out, .line_oe,
        .resistive_term_on, .capacitive_term_on, .user_switch_bits);
    scior_line_model scior_line_model_inst (.sys_clk, .line_out, .line_oe, .line_in);
    // Expected-value helpers
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [21:0] drv(input logic [21:0] mx, sm, rg);
        return (mx & sm) | (~mx & rg);
    endfunction
    // Host cycles: strobe held for exactly one taking edge
    task automatic chk(input string n, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= x;
        @(posedge sys_clk);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x);
        rd(a);
        chk(n, v, x);
    endtask
    task automatic finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        foreach (OFFS[i])
            rc("reset", OFFS[i], '0);
        wr(8'h04, '1);
        rc("id", 8'h04, 32'h00a5_0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            rnd = nxt(rnd);
            d = i < 3 ? BASES[i] : rnd;
            chan_irq <= i < 3 ? '0 : rnd[31:12];
            wr(8'h00, d);
            rc("base", 8'h00, d & 32'h0000_001f);
            chk("irq", carrier_irq, d[0] & (d[1] | (i > 2 && rnd[31:12] != 0)));
            chk("ref", ref_clk_select, d[4]);
            chk("msg", {message_event_clear, message_interrupt_enable}, d[3:2]);
        end
        $display("test base done");
        rnd = nxt(rnd);
        wr(8'h08, rnd);
        wr(8'h08, '0);
        rc("set", 8'h08, rnd & 32'h000f_ffff);
        wr(8'h0c, 32'hfff0_00ff);
        rc("clear", 8'h08, rnd & 32'h000f_ff00);
        @(posedge sys_clk);
        chan_start_done <= 20'h0_ff00;
        @(posedge sys_clk);
        chan_start_done <= '0;
        rc("self", 8'h08, rnd & 32'h000f_0000);
        $display("test start done");
        d = nxt(rnd);
        m = nxt(d);
        r = nxt(m);
        e = drv(m[21:0], r[31:10], r[21:0]);
        sm_line_out <= r[21:0];
        sm_line_oe <= r[31:10];
        wr(8'h10, d);
        wr(8'h14, r);
        wr(8'h1c, m);
        wr(8'h18, m);
        wr(8'hc8, d & 32'h7fff_ffff);
        rc("data", 8'h10, d & 32'h003f_ffff);
        rc("dir", 8'h14, r & 32'h003f_ffff);
        rc("mux", 8'h1c, m & 32'h003f_ffff);
        rc("cap", 8'hc8, d & 32'h000f_ffff);
        chk("oe", line_oe, e);
        chk("out", line_out & e, drv(m[21:0], r[21:0], d[21:0]) & e);
        chk("rterm", resistive_term_on, m[21:0]);
        chk("cterm", capacitive_term_on, d[19:0]);
        rd(8'hc0);
        chk("pins", v & {10'h3ff, e}, {10'h0, drv(m[21:0], r[21:0], d[21:0]) & e});
        wr(8'hc8, 32'h8000_0000);
        rc("tsel", 8'hc8, 32'h8000_0000);
        chk("test oe", line_oe, {e[21:20], 20'hf_ffff});
        $display("test lines done");
        user_switch_bits <= rnd[7:0];
        wr(8'h20, '1);
        rc("upper", 8'h20, '0);
        wr(8'hfc, '1);
        rc("spare", 8'hfc, '0);
        rc("switch", 8'h24, {8'h0, rnd[7:0], 16'h0});
        $display("test status done");
        finish_test();
    end
    // Watchdog against a hung sequence
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
